// ---- rtl/cms_mode_select.sv ----
// Mode select, stack bank and call sequencing for a 4-bit core.
// Assumes one request per idle cycle on the machine-cycle clock.
`timescale 1ns/1ps
`include "cms_defs.svh"
module cms_mode_select (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic selWrEn,
    input wire logic [3:0] selWrData,
    input wire logic reqValid,
    input wire cms_pkg::cms_req_s req,
    input wire logic [13:0] pcCurrent,
    output logic [3:0] selRdData,
    output cms_pkg::cms_mode_s modeOut,
    output logic busy,
    output logic illegalOp,
    output logic stackWrEn,
    output logic [8:0] stackAddr,
    output logic [3:0] stackWrData,
    output logic pcLoad,
    output logic [13:0] pcNext
);
    typedef enum logic [1:0] {CMS_IDLE, CMS_PUSH, CMS_WAIT} cms_state_e;

    logic [3:0] sel_q, sel_d;
    cms_state_e state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] bytesLeft_q, bytesLeft_d;
    logic [13:0] retPc_q, retPc_d, tgt_q, tgt_d;
    logic [7:0] sp_q, sp_d;
    logic [13:0] savedPc [0:255];
    logic illegal_q, illegal_d;
    logic wr_q, wr_d;
    logic [3:0] wrData_q, wrData_d;
    logic pcLoad_q, pcLoad_d;
    logic [13:0] pcNext_q, pcNext_d;
    logic [1:0] pushBytes;
    logic [2:0] callCycles;
    logic legacy;
    logic isCall, isRet;

    assign legacy = sel_q[`CMS_MODE_BIT];

    cms_timing u_timing (
        .legacyMode(legacy),
        .op(req.op),
        .pushBytes(pushBytes),
        .callCycles(callCycles)
    );

    always_comb begin
        sel_d = sel_q;
        if (selWrEn) begin
            sel_d = selWrData;
        end
    end

    always_comb begin
        isCall = reqValid && (req.op == cms_pkg::CMS_OP_CALL_ABS
            || req.op == cms_pkg::CMS_OP_CALL_FIX
            || (req.op == cms_pkg::CMS_OP_EXT_CALL && !legacy));
        isRet = reqValid && req.op == cms_pkg::CMS_OP_RETURN && sp_q != 8'h00;
        state_d = state_q;
        cnt_d = cnt_q;
        bytesLeft_d = bytesLeft_q;
        retPc_d = retPc_q;
        tgt_d = tgt_q;
        sp_d = sp_q;
        illegal_d = 1'b0;
        wr_d = 1'b0;
        wrData_d = wrData_q;
        pcLoad_d = 1'b0;
        pcNext_d = pcNext_q;
        case (state_q)
            CMS_IDLE: begin
                if (reqValid && legacy && (req.op == cms_pkg::CMS_OP_EXT_BRANCH
                    || req.op == cms_pkg::CMS_OP_EXT_CALL)) begin
                    illegal_d = 1'b1;
                end else if (reqValid && req.op == cms_pkg::CMS_OP_EXT_BRANCH) begin
                    pcLoad_d = 1'b1;
                    pcNext_d = req.target;
                end else if (isCall) begin
                    retPc_d = pcCurrent;
                    tgt_d = req.target;
                    bytesLeft_d = pushBytes;
                    cnt_d = (req.op == cms_pkg::CMS_OP_EXT_CALL) ?
                        `CMS_CALL_ABS_EXT : callCycles;
                    state_d = CMS_PUSH;
                end else if (isRet) begin
                    // Extended mode restores all bits; legacy keeps the low 12
                    pcLoad_d = 1'b1;
                    pcNext_d = legacy ? {pcCurrent[13:12], savedPc[sp_q - 8'h01][11:0]}
                        : savedPc[sp_q - 8'h01];
                    sp_d = sp_q - 8'h01;
                end
            end
            CMS_PUSH: begin
                wr_d = 1'b1;
                case (bytesLeft_q)
                    2'h3: wrData_d = {2'b00, retPc_q[13:12]};
                    2'h2: wrData_d = retPc_q[11:8];
                    default: wrData_d = retPc_q[7:4];
                endcase
                bytesLeft_d = bytesLeft_q - 2'h1;
                cnt_d = cnt_q - 3'h1;
                if (bytesLeft_q == 2'h1) begin
                    sp_d = sp_q + 8'h01;
                    if (cnt_q <= 3'h1) begin
                        // Fixed calls jump with the last push; absolute and extended calls wait one cycle more
                        pcLoad_d = 1'b1;
                        pcNext_d = tgt_q;
                        state_d = CMS_IDLE;
                    end else begin
                        state_d = CMS_WAIT;
                    end
                end
            end
            CMS_WAIT: begin
                // Pad out to the documented call length
                cnt_d = cnt_q - 3'h1;
                if (cnt_q <= 3'h1) begin
                    pcLoad_d = 1'b1;
                    pcNext_d = tgt_q;
                    state_d = CMS_IDLE;
                end
            end
            default: begin
                state_d = CMS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_q <= `CMS_SEL_RESET;
            state_q <= CMS_IDLE;
            cnt_q <= 3'h0;
            bytesLeft_q <= 2'h0;
            retPc_q <= 14'h0000;
            tgt_q <= 14'h0000;
            sp_q <= 8'h00;
            illegal_q <= 1'b0;
            wr_q <= 1'b0;
            wrData_q <= 4'h0;
            pcLoad_q <= 1'b0;
            pcNext_q <= 14'h0000;
        end else begin
            sel_q <= sel_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            bytesLeft_q <= bytesLeft_d;
            retPc_q <= retPc_d;
            tgt_q <= tgt_d;
            sp_q <= sp_d;
            illegal_q <= illegal_d;
            wr_q <= wr_d;
            wrData_q <= wrData_d;
            pcLoad_q <= pcLoad_d;
            pcNext_q <= pcNext_d;
        end
    end

    // Return address shadow; plain array, no reset needed
    always_ff @(posedge clk_sys) begin
        if (state_q == CMS_PUSH && bytesLeft_q == 2'h1) begin
            savedPc[sp_q] <= retPc_q;
        end
    end

    logic [8:0] addr_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_q <= 9'h000;
        end else begin
            addr_q <= {sel_q[`CMS_BANK_BIT], sp_q};
        end
    end

    logic [3:0] rd_q;
    cms_pkg::cms_mode_s mode_q;
    logic busy_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_q <= `CMS_SEL_RESET;
            mode_q <= '{legacyMode: 1'b1, stackBank: 1'b0, pushBytes: `CMS_PUSH_LEGACY,
                callCycles: 3'h1};
            busy_q <= 1'b0;
        end else begin
            rd_q <= sel_q;
            mode_q <= '{legacyMode: legacy, stackBank: sel_q[`CMS_BANK_BIT],
                pushBytes: pushBytes, callCycles: callCycles};
            busy_q <= state_d != CMS_IDLE;
        end
    end

    assign selRdData = rd_q;
    assign modeOut = mode_q;
    assign busy = busy_q;
    assign illegalOp = illegal_q;
    assign stackWrEn = wr_q;
    assign stackAddr = addr_q;
    assign stackWrData = wrData_q;
    assign pcLoad = pcLoad_q;
    assign pcNext = pcNext_q;

    reset_mode_a: assert property (@(posedge clk_sys) $fell(srst) |-> sel_q[3] == 1'b1)
        else $error("mode bit not set after reset");
    write_both_a: assert property (@(posedge clk_sys) disable iff (srst)
        selWrEn |=> sel_q == $past(selWrData))
        else $error("select write lost");
    ext_block_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && reqValid && legacy
        && req.op == cms_pkg::CMS_OP_EXT_BRANCH) |=> illegalOp && !pcLoad)
        else $error("extended branch ran in legacy mode");
    // Pushes start in the push state and are registered, so the first write shows two cycles after the request
    push_legacy_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && legacy)
        |=> !stackWrEn ##1 stackWrEn[*2] ##1 !stackWrEn)
        else $error("legacy call push count wrong");
    push_ext_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && !legacy)
        |=> !stackWrEn ##1 stackWrEn[*3] ##1 !stackWrEn)
        else $error("extended call push count wrong");
    abs_legacy_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && legacy && req.op == cms_pkg::CMS_OP_CALL_ABS)
        |=> !pcLoad[*3] ##1 pcLoad)
        else $error("legacy absolute call length wrong");
    abs_ext_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && !legacy && req.op == cms_pkg::CMS_OP_CALL_ABS)
        |=> !pcLoad[*4] ##1 pcLoad)
        else $error("extended absolute call length wrong");
    fix_legacy_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && legacy && req.op == cms_pkg::CMS_OP_CALL_FIX)
        |=> !pcLoad[*2] ##1 pcLoad)
        else $error("legacy fixed call length wrong");
    fix_ext_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_q == CMS_IDLE && isCall && !legacy && req.op == cms_pkg::CMS_OP_CALL_FIX)
        |=> !pcLoad[*3] ##1 pcLoad)
        else $error("extended fixed call length wrong");
    bank_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 stackAddr[8] == $past(sel_q[0]))
        else $error("stack bank not from select register");
endmodule : cms_mode_select

// ---- rtl/cms_defs.svh ----
// Constants for the compatibility mode and stack select block.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CMS_MODE_BIT 3
`define CMS_BANK_BIT 0
`define CMS_SEL_RESET 4'h8
`define CMS_SEL_WIDTH 4
`define CMS_PC_WIDTH 14
`define CMS_PUSH_LEGACY 2'h2
`define CMS_PUSH_EXT 2'h3
`define CMS_CALL_ABS_LEGACY 3'h3
`define CMS_CALL_ABS_EXT 3'h4
`define CMS_CALL_FIX_LEGACY 3'h2
`define CMS_CALL_FIX_EXT 3'h3
`endif

// ---- rtl/cms_pkg.sv ----
// Types shared by the mode select block.
// Assumes cms_defs.svh is compiled alongside.
package cms_pkg;
    typedef enum logic [2:0] {
        CMS_OP_NONE,
        CMS_OP_CALL_ABS,
        CMS_OP_CALL_FIX,
        CMS_OP_EXT_BRANCH,
        CMS_OP_EXT_CALL,
        CMS_OP_RETURN
    } cms_op_e;

    typedef struct packed {
        cms_op_e op;
        logic [13:0] target;
    } cms_req_s;

    typedef struct packed {
        logic legacyMode;
        logic stackBank;
        logic [1:0] pushBytes;
        logic [2:0] callCycles;
    } cms_mode_s;
endpackage : cms_pkg

// ---- rtl/cms_timing.sv ----
// Per-mode push nibble counts and call cycle counts.
// Pure combinational; fed from the select register in the same clock.
`timescale 1ns/1ps
`include "cms_defs.svh"
module cms_timing (
    input wire logic legacyMode,
    input wire cms_pkg::cms_op_e op,
    output logic [1:0] pushBytes,
    output logic [2:0] callCycles
);
    always_comb begin
        pushBytes = legacyMode ? `CMS_PUSH_LEGACY : `CMS_PUSH_EXT;
        case (op)
            cms_pkg::CMS_OP_CALL_ABS: begin
                callCycles = legacyMode ? `CMS_CALL_ABS_LEGACY : `CMS_CALL_ABS_EXT;
            end
            cms_pkg::CMS_OP_CALL_FIX: begin
                callCycles = legacyMode ? `CMS_CALL_FIX_LEGACY : `CMS_CALL_FIX_EXT;
            end
            default: begin
                callCycles = 3'h1;
            end
        endcase
    end
endmodule : cms_timing

// ---- tb/cms_mode_select_tb.sv ----
// Self-checking bench for the mode select block: select writes, calls, returns, branches.
// Assumes the rtl/ package, header and sources are compiled first; inputs move on falling edges.
`timescale 1ns/1ps
module cms_mode_select_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic selWrEn = 1'b0;
    logic [3:0] selWrData = 4'h0;
    logic reqValid = 1'b0;
    cms_pkg::cms_req_s req = '0;
    logic [13:0] pcCurrent = 14'h0000;
    logic [3:0] selRdData;
    cms_pkg::cms_mode_s modeOut;
    logic busy, illegalOp, stackWrEn, pcLoad;
    logic [8:0] stackAddr;
    logic [3:0] stackWrData;
    logic [13:0] pcNext, saved, t;
    logic [3:0] v;
    logic leg;
    cms_pkg::cms_op_e o;
    int mismatches = 0;
    int n_compared = 0;

    always #4 clk_sys = ~clk_sys;

    cms_mode_select u_cms_mode_select (.clk_sys(clk_sys), .srst(srst), .selWrEn(selWrEn),
        .selWrData(selWrData), .reqValid(reqValid), .req(req), .pcCurrent(pcCurrent),
        .selRdData(selRdData), .modeOut(modeOut), .busy(busy), .illegalOp(illegalOp),
        .stackWrEn(stackWrEn), .stackAddr(stackAddr), .stackWrData(stackWrData),
        .pcLoad(pcLoad), .pcNext(pcNext));

    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Cycle at which the jump lands: one past the documented call length
    function automatic int loadAt(input logic lg, input cms_pkg::cms_op_e op);
        if (op == cms_pkg::CMS_OP_CALL_FIX) return lg ? 3 : 4;
        return lg ? 4 : 5;
    endfunction : loadAt

    // Nibble n of a call's push, oldest first; legacy drops the top two bits
    function automatic logic [15:0] pushNib(input logic lg, input logic [13:0] pc, input int n);
        if (!lg && n == 0) return {14'h0000, pc[13:12]};
        if ((lg && n == 0) || (!lg && n == 1)) return {12'h000, pc[11:8]};
        return {12'h000, pc[7:4]};
    endfunction : pushNib

    // One request, then a fixed look of 8 cycles, long enough for the slowest call
    task automatic run(input cms_pkg::cms_op_e op, input logic [13:0] tg, input int expLd,
                       input int expWr, input logic expIll, input logic [13:0] expPc);
        int ld = 0;
        int wr = 0;
        logic il = 1'b0;
        logic [13:0] pcSeen = 14'h0000;
        @(negedge clk_sys);
        reqValid = 1'b1;
        req.op = op;
        req.target = tg;
        for (int k = 1; k <= 8; k++) begin
            @(negedge clk_sys);
            reqValid = 1'b0;
            if (stackWrEn === 1'b1) begin
                chk("stack bank", {15'h0000, v[0]}, {15'h0000, stackAddr[8]});
                chk("push nibble", pushNib(leg, saved, wr), {12'h0, stackWrData});
                wr++;
            end
            if (k == 1 && (op == cms_pkg::CMS_OP_CALL_ABS
                || op == cms_pkg::CMS_OP_CALL_FIX)) begin
                chk("call len", 16'(loadAt(leg, op) - 1), {13'h0, modeOut.callCycles});
            end
            if (pcLoad === 1'b1 && ld == 0) begin
                ld = k;
                pcSeen = pcNext;
            end
            if (illegalOp === 1'b1) il = 1'b1;
        end
        chk("load cycle", 16'(expLd), 16'(ld));
        chk("stack writes", 16'(expWr), 16'(wr));
        chk("illegal flag", {15'h0000, expIll}, {15'h0000, il});
        chk("busy idle", 16'h0000, {15'h0000, busy});
        if (expLd != 0) chk("pc target", {2'h0, expPc}, {2'h0, pcSeen});
    endtask : run

    initial begin
        void'($urandom(69));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("select reset", 16'h0008, {12'h000, selRdData});
        chk("legacy after reset", 16'h0001, {15'h0000, modeOut.legacyMode});
        // Empty stack: a return must be ignored
        run(cms_pkg::CMS_OP_RETURN, 14'h0000, 0, 0, 1'b0, 14'h0000);
        for (int i = 0; i < 14; i++) begin
            v = (i == 0) ? 4'h9 : (i == 1) ? 4'h1 : 4'($urandom);
            leg = v[3];
            @(negedge clk_sys);
            selWrEn = 1'b1;
            selWrData = v;
            @(negedge clk_sys);
            selWrEn = 1'b0;
            @(negedge clk_sys);
            chk("select readback", {12'h000, v}, {12'h000, selRdData});
            chk("legacy flag", {15'h0000, leg}, {15'h0000, modeOut.legacyMode});
            chk("bank flag", {15'h0000, v[0]}, {15'h0000, modeOut.stackBank});
            chk("push bytes", leg ? 16'h0002 : 16'h0003, {14'h0000, modeOut.pushBytes});
            for (int j = 0; j < 3; j++) begin
                o = (j == 0) ? cms_pkg::CMS_OP_CALL_ABS :
                    (j == 1) ? cms_pkg::CMS_OP_CALL_FIX : cms_pkg::CMS_OP_EXT_CALL;
                saved = 14'($urandom);
                pcCurrent = saved;
                t = 14'($urandom);
                if (j == 2 && leg) begin
                    run(o, t, 0, 0, 1'b1, t);
                end else begin
                    run(o, t, loadAt(leg, o), leg ? 2 : 3, 1'b0, t);
                    // Fresh upper bits show what a legacy return keeps
                    pcCurrent = 14'($urandom);
                    run(cms_pkg::CMS_OP_RETURN, t, 1, 0, 1'b0,
                        leg ? {pcCurrent[13:12], saved[11:0]} : saved);
                end
            end
            t = 14'($urandom);
            run(cms_pkg::CMS_OP_EXT_BRANCH, t, leg ? 0 : 1, 0, leg, t);
        end
        // Mid-run reset from extended mode with a live stack entry
        v = 4'h1;
        leg = 1'b0;
        @(negedge clk_sys);
        selWrEn = 1'b1;
        selWrData = v;
        @(negedge clk_sys);
        selWrEn = 1'b0;
        saved = 14'($urandom);
        pcCurrent = saved;
        t = 14'($urandom);
        run(cms_pkg::CMS_OP_CALL_ABS, t, 5, 3, 1'b0, t);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("select mid reset", 16'h0008, {12'h000, selRdData});
        chk("legacy mid reset", 16'h0001, {15'h0000, modeOut.legacyMode});
        chk("bank mid reset", 16'h0000, {15'h0000, modeOut.stackBank});
        // Reset empties the stack, so this return must be ignored
        run(cms_pkg::CMS_OP_RETURN, 14'h0000, 0, 0, 1'b0, 14'h0000);
        summarize();
    end

    // Roughly 14 rounds of under 100 cycles each; this leaves a wide margin
    initial begin
        #200_000;
        mismatches++;
        summarize();
    end
endmodule : cms_mode_select_tb
